// [rtl/cbx_exec.sv]
`timescale 1ns/100ps

module cbx_exec (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        narrow_bus,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  modrm,
  input  wire logic [15:0] imm_word0,
  input  wire logic [15:0] imm_word1,
  input  wire logic [15:0] instr_addr,
  input  wire logic [15:0] next_instr_addr,
  input  wire logic [15:0] operand_reg,
  input  wire logic [15:0] operand_addr,
  input  wire logic        operand_uses_stack,
  input  wire logic [15:0] operand_disp,
  input  wire logic [15:0] code_segment_in,
  input  wire logic [15:0] stack_pointer_in,
  input  wire logic [15:0] accumulator_word_in,
  input  wire logic        load_state,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             busy,
  output logic             instr_done,
  output logic             trap_req,
  output logic      [7:0]  trap_vector,
  output logic      [15:0] instruction_pointer,
  output logic      [15:0] code_segment,
  output logic      [15:0] stack_pointer,
  output logic      [15:0] accumulator_word,
  output logic             carry_flag
);

  typedef enum logic [3:0] {
    CBX_S_IDLE,
    CBX_S_FETCH_LO,
    CBX_S_FETCH_HI,
    CBX_S_PUSH_SEG,
    CBX_S_PUSH_OFF,
    CBX_S_POP,
    CBX_S_WAIT,
    CBX_S_FINISH
  } cbx_state_t;

  cbx_state_t         state;
  cbx_pkg::cbx_kind_t kind;
  cbx_pkg::cbx_kind_t dec_kind;
  logic [5:0]         dec_clocks;
  logic [5:0]         cycle_left;
  logic [15:0]        op_addr;
  logic [15:0]        ret_off;
  logic [15:0]        first_word;
  logic [15:0]        target_off;
  logic [15:0]        target_seg;
  logic               out_of_range;
  logic               acc_start;
  logic               acc_write;
  logic [15:0]        acc_addr;
  logic [15:0]        acc_wdata;
  logic               acc_done;
  logic [15:0]        acc_rdata;
  logic [15:0]        base_addr;

  // ****************************************
  // Decode and word access
  // ****************************************
  cbx_decode u_decode (
    .opcode     (opcode),
    .modrm      (modrm),
    .narrow_bus (narrow_bus),
    .kind       (dec_kind),
    .clocks     (dec_clocks)
  );

  cbx_word_bus u_bus (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (acc_start),
    .write     (acc_write),
    .addr      (acc_addr),
    .wdata     (acc_wdata),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata),
    .done      (acc_done),
    .rdata     (acc_rdata)
  );

  // Stack-based operand uses the pointer before any push
  assign base_addr = operand_uses_stack ? 16'(stack_pointer + operand_disp) : operand_addr;

  // ****************************************
  // Access requests per state
  // ****************************************
  always_comb
  begin
    acc_start = 1'b0;
    acc_write = 1'b0;
    acc_addr  = op_addr;
    acc_wdata = ret_off;
    if (state == CBX_S_IDLE && instr_valid && !load_state)
    begin
      unique case (dec_kind)
        cbx_pkg::CBX_K_NEAR_MEM, cbx_pkg::CBX_K_FAR_MEM, cbx_pkg::CBX_K_BOUND:
        begin
          acc_start = 1'b1;
          acc_addr  = base_addr;
        end
        cbx_pkg::CBX_K_NEAR_REL, cbx_pkg::CBX_K_NEAR_REG:
        begin
          acc_start = 1'b1;
          acc_write = 1'b1;
          acc_addr  = 16'(stack_pointer - cbx_pkg::WORD_STEP);
          acc_wdata = next_instr_addr;
        end
        cbx_pkg::CBX_K_FAR_IMM:
        begin
          acc_start = 1'b1;
          acc_write = 1'b1;
          acc_addr  = 16'(stack_pointer - cbx_pkg::WORD_STEP);
          acc_wdata = code_segment;
        end
        cbx_pkg::CBX_K_RETURN:
        begin
          acc_start = 1'b1;
          acc_addr  = stack_pointer;
        end
        default:
        begin
          acc_start = 1'b0;
        end
      endcase
    end
    else if (acc_done)
    begin
      unique case (state)
        CBX_S_FETCH_LO:
        begin
          if (kind != cbx_pkg::CBX_K_NEAR_MEM)
          begin
            acc_start = 1'b1;
            acc_addr  = 16'(op_addr + cbx_pkg::WORD_STEP);
          end
          else
          begin
            acc_start = 1'b1;
            acc_write = 1'b1;
            acc_addr  = 16'(stack_pointer - cbx_pkg::WORD_STEP);
          end
        end
        CBX_S_FETCH_HI:
        begin
          acc_start = kind == cbx_pkg::CBX_K_FAR_MEM;
          acc_write = 1'b1;
          acc_addr  = 16'(stack_pointer - cbx_pkg::WORD_STEP);
          acc_wdata = code_segment;
        end
        CBX_S_PUSH_SEG:
        begin
          acc_start = 1'b1;
          acc_write = 1'b1;
          acc_addr  = 16'(mem_addr - cbx_pkg::WORD_STEP);
        end
        default:
        begin
          acc_start = 1'b0;
        end
      endcase
    end
  end

  assign out_of_range = ($signed(operand_reg) < $signed(first_word)) ||
                        ($signed(operand_reg) > $signed(acc_rdata));

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state      <= CBX_S_IDLE;
      kind       <= cbx_pkg::CBX_K_NONE;
      cycle_left <= 6'd0;
      op_addr    <= cbx_pkg::PTR_RESET;
      ret_off    <= cbx_pkg::PTR_RESET;
      first_word <= cbx_pkg::PTR_RESET;
      target_off <= cbx_pkg::PTR_RESET;
      target_seg <= cbx_pkg::PTR_RESET;
      busy       <= 1'b0;
    end
    else
    begin
      if (cycle_left != 6'd0)
      begin
        cycle_left <= cycle_left - 6'd1;
      end
      unique case (state)
        CBX_S_IDLE:
        begin
          if (instr_valid && !load_state)
          begin
            kind       <= dec_kind;
            cycle_left <= dec_clocks - 6'd1;
            op_addr    <= base_addr;
            ret_off    <= next_instr_addr;
            target_seg <= code_segment;
            busy       <= 1'b1;
            unique case (dec_kind)
              cbx_pkg::CBX_K_NEAR_REL:
              begin
                target_off <= 16'(next_instr_addr + imm_word0);
                state      <= CBX_S_PUSH_OFF;
              end
              cbx_pkg::CBX_K_NEAR_REG:
              begin
                target_off <= operand_reg;
                state      <= CBX_S_PUSH_OFF;
              end
              cbx_pkg::CBX_K_FAR_IMM:
              begin
                target_off <= imm_word0;
                target_seg <= imm_word1;
                state      <= CBX_S_PUSH_SEG;
              end
              cbx_pkg::CBX_K_NEAR_MEM, cbx_pkg::CBX_K_FAR_MEM, cbx_pkg::CBX_K_BOUND:
              begin
                state <= CBX_S_FETCH_LO;
              end
              cbx_pkg::CBX_K_RETURN:
              begin
                state <= CBX_S_POP;
              end
              default:
              begin
                target_off <= next_instr_addr;
                state      <= CBX_S_WAIT;
              end
            endcase
          end
        end
        CBX_S_FETCH_LO:
        begin
          if (acc_done)
          begin
            first_word <= acc_rdata;
            target_off <= acc_rdata;
            state      <= kind == cbx_pkg::CBX_K_NEAR_MEM ? CBX_S_PUSH_OFF : CBX_S_FETCH_HI;
          end
        end
        CBX_S_FETCH_HI:
        begin
          if (acc_done)
          begin
            if (kind == cbx_pkg::CBX_K_FAR_MEM)
            begin
              target_seg <= acc_rdata;
              state      <= CBX_S_PUSH_SEG;
            end
            else
            begin
              target_off <= out_of_range ? instr_addr : next_instr_addr;
              state      <= CBX_S_WAIT;
            end
          end
        end
        CBX_S_PUSH_SEG:
        begin
          if (acc_done)
          begin
            state <= CBX_S_PUSH_OFF;
          end
        end
        CBX_S_PUSH_OFF, CBX_S_POP:
        begin
          if (acc_done)
          begin
            if (state == CBX_S_POP)
            begin
              target_off <= acc_rdata;
            end
            state <= CBX_S_WAIT;
          end
        end
        CBX_S_WAIT:
        begin
          if (cycle_left <= 6'd1)
          begin
            state <= CBX_S_FINISH;
          end
        end
        CBX_S_FINISH:
        begin
          busy  <= 1'b0;
          state <= CBX_S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Architectural state and completion
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      instruction_pointer <= cbx_pkg::PTR_RESET;
      code_segment        <= cbx_pkg::PTR_RESET;
      stack_pointer       <= cbx_pkg::PTR_RESET;
      accumulator_word    <= cbx_pkg::PTR_RESET;
      carry_flag          <= 1'b0;
      instr_done          <= 1'b0;
      trap_req            <= 1'b0;
      trap_vector         <= 8'h00;
    end
    else if (load_state && state == CBX_S_IDLE)
    begin
      code_segment     <= code_segment_in;
      stack_pointer    <= stack_pointer_in;
      accumulator_word <= accumulator_word_in;
      instr_done       <= 1'b0;
      trap_req         <= 1'b0;
    end
    else
    begin
      instr_done <= state == CBX_S_FINISH;
      trap_req   <= 1'b0;
      if (acc_done && mem_we)
      begin
        stack_pointer <= mem_addr;
      end
      if (acc_done && state == CBX_S_POP)
      begin
        stack_pointer <= 16'(stack_pointer + cbx_pkg::WORD_STEP);
      end
      if (state == CBX_S_FINISH)
      begin
        instruction_pointer <= target_off;
        code_segment        <= target_seg;
        if (kind == cbx_pkg::CBX_K_SIGN_EXT)
        begin
          accumulator_word[15:8] <= accumulator_word[7] ? cbx_pkg::SIGN_FILL_ONES
                                                        : cbx_pkg::SIGN_FILL_ZEROS;
        end
        if (kind == cbx_pkg::CBX_K_CLR_CARRY)
        begin
          carry_flag <= 1'b0;
        end
        if (kind == cbx_pkg::CBX_K_BOUND && target_off == instr_addr)
        begin
          trap_req    <= 1'b1;
          trap_vector <= cbx_pkg::BOUND_TRAP_VEC;
        end
      end
    end
  end

endmodule

// [common/cbx_pkg.sv]
package cbx_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_CALL_NEAR_REL  = 8'he8;
  localparam logic [7:0] OP_CALL_FAR_IMM   = 8'h9a;
  localparam logic [7:0] OP_GROUP_FF       = 8'hff;
  localparam logic [7:0] OP_SIGN_EXTEND    = 8'h98;
  localparam logic [7:0] OP_CLEAR_CARRY    = 8'hf8;
  localparam logic [7:0] OP_BOUND_CHECK    = 8'h62;
  localparam logic [7:0] OP_NEAR_RETURN    = 8'hc3;
  localparam logic [2:0] FF_REG_CALL_NEAR  = 3'h2;
  localparam logic [2:0] FF_REG_CALL_FAR   = 3'h3;
  localparam logic [1:0] MOD_REGISTER      = 2'h3;

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [7:0]  SIGN_FILL_ONES   = 8'hff;
  localparam logic [7:0]  SIGN_FILL_ZEROS  = 8'h00;
  localparam logic [15:0] WORD_STEP        = 16'h0002;
  localparam logic [7:0]  BOUND_TRAP_VEC   = 8'h05;
  localparam logic [15:0] PTR_RESET        = 16'h0000;

  // ****************************************
  // Clock counts, 16-bit bus / 8-bit bus
  // ****************************************
  localparam logic [5:0] CLK_NEAR_REL_W    = 6'd15;
  localparam logic [5:0] CLK_NEAR_REL_B    = 6'd19;
  localparam logic [5:0] CLK_NEAR_REG_W    = 6'd13;
  localparam logic [5:0] CLK_NEAR_REG_B    = 6'd17;
  localparam logic [5:0] CLK_NEAR_MEM_W    = 6'd19;
  localparam logic [5:0] CLK_NEAR_MEM_B    = 6'd27;
  localparam logic [5:0] CLK_FAR_IMM_W     = 6'd23;
  localparam logic [5:0] CLK_FAR_IMM_B     = 6'd31;
  localparam logic [5:0] CLK_FAR_MEM_W     = 6'd38;
  localparam logic [5:0] CLK_FAR_MEM_B     = 6'd54;
  localparam logic [5:0] CLK_SIMPLE        = 6'd2;
  localparam logic [5:0] CLK_BOUND         = 6'd33;
  localparam logic [5:0] CLK_RETURN        = 6'd16;
  localparam logic [5:0] CLK_UNKNOWN       = 6'd2;

  typedef enum logic [3:0] {
    CBX_K_NONE,
    CBX_K_NEAR_REL,
    CBX_K_NEAR_REG,
    CBX_K_NEAR_MEM,
    CBX_K_FAR_IMM,
    CBX_K_FAR_MEM,
    CBX_K_SIGN_EXT,
    CBX_K_CLR_CARRY,
    CBX_K_BOUND,
    CBX_K_RETURN
  } cbx_kind_t;

endpackage

// [rtl/cbx_decode.sv]
`timescale 1ns/100ps

module cbx_decode (
  input  wire logic [7:0]        opcode,
  input  wire logic [7:0]        modrm,
  input  wire logic              narrow_bus,
  output cbx_pkg::cbx_kind_t     kind,
  output logic      [5:0]        clocks
);

  // ****************************************
  // Instruction class and clock count
  // ****************************************
  always_comb
  begin
    kind   = cbx_pkg::CBX_K_NONE;
    clocks = cbx_pkg::CLK_UNKNOWN;
    unique case (opcode)
      cbx_pkg::OP_CALL_NEAR_REL:
      begin
        kind   = cbx_pkg::CBX_K_NEAR_REL;
        clocks = narrow_bus ? cbx_pkg::CLK_NEAR_REL_B : cbx_pkg::CLK_NEAR_REL_W;
      end
      cbx_pkg::OP_CALL_FAR_IMM:
      begin
        kind   = cbx_pkg::CBX_K_FAR_IMM;
        clocks = narrow_bus ? cbx_pkg::CLK_FAR_IMM_B : cbx_pkg::CLK_FAR_IMM_W;
      end
      cbx_pkg::OP_GROUP_FF:
      begin
        if (modrm[5:3] == cbx_pkg::FF_REG_CALL_NEAR)
        begin
          if (modrm[7:6] == cbx_pkg::MOD_REGISTER)
          begin
            kind   = cbx_pkg::CBX_K_NEAR_REG;
            clocks = narrow_bus ? cbx_pkg::CLK_NEAR_REG_B : cbx_pkg::CLK_NEAR_REG_W;
          end
          else
          begin
            kind   = cbx_pkg::CBX_K_NEAR_MEM;
            clocks = narrow_bus ? cbx_pkg::CLK_NEAR_MEM_B : cbx_pkg::CLK_NEAR_MEM_W;
          end
        end
        else if (modrm[5:3] == cbx_pkg::FF_REG_CALL_FAR && modrm[7:6] != cbx_pkg::MOD_REGISTER)
        begin
          kind   = cbx_pkg::CBX_K_FAR_MEM;
          clocks = narrow_bus ? cbx_pkg::CLK_FAR_MEM_B : cbx_pkg::CLK_FAR_MEM_W;
        end
      end
      cbx_pkg::OP_SIGN_EXTEND:
      begin
        kind   = cbx_pkg::CBX_K_SIGN_EXT;
        clocks = cbx_pkg::CLK_SIMPLE;
      end
      cbx_pkg::OP_CLEAR_CARRY:
      begin
        kind   = cbx_pkg::CBX_K_CLR_CARRY;
        clocks = cbx_pkg::CLK_SIMPLE;
      end
      cbx_pkg::OP_BOUND_CHECK:
      begin
        kind   = cbx_pkg::CBX_K_BOUND;
        clocks = cbx_pkg::CLK_BOUND;
      end
      cbx_pkg::OP_NEAR_RETURN:
      begin
        kind   = cbx_pkg::CBX_K_RETURN;
        clocks = cbx_pkg::CLK_RETURN;
      end
      default:
      begin
        kind   = cbx_pkg::CBX_K_NONE;
        clocks = cbx_pkg::CLK_UNKNOWN;
      end
    endcase
  end

endmodule

// [rtl/cbx_word_bus.sv]
`timescale 1ns/100ps

module cbx_word_bus (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             done,
  output logic      [15:0] rdata
);

  // ****************************************
  // One word access, held until acknowledged
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
    end
    else if (start)
    begin
      mem_req   <= 1'b1;
      mem_we    <= write;
      mem_addr  <= addr;
      mem_wdata <= wdata;
    end
    else if (mem_ack)
    begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      done  <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      done <= mem_req && mem_ack;
      if (mem_req && mem_ack)
      begin
        rdata <= mem_rdata;
      end
    end
  end

endmodule

// [dv/cbx_exec_sva.sv]
`timescale 1ns/100ps
// ****
// Checker
// ****
module cbx_exec_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  modrm,
  input wire logic [15:0] imm_word0,
  input wire logic [15:0] imm_word1,
  input wire logic [15:0] instr_addr,
  input wire logic [15:0] next_instr_addr,
  input wire logic [15:0] operand_reg,
  input wire logic        load_state,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        busy,
  input wire logic        instr_done,
  input wire logic        trap_req,
  input wire logic [7:0]  trap_vector,
  input wire logic [15:0] instruction_pointer,
  input wire logic [15:0] code_segment,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] accumulator_word,
  input wire logic        carry_flag
);
  logic start;
  assign start = instr_valid && !busy && !load_state;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_trap_vec;
    trap_req |-> instr_done && trap_vector == cbx_pkg::BOUND_TRAP_VEC;
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("bad trap");
  property p_trap_ip;
    trap_req |-> instruction_pointer == instr_addr;
  endproperty
  a_trap_ip: assert property (p_trap_ip) else $error("bad trap ip");
  property p_clc;
    start && opcode == cbx_pkg::OP_CLEAR_CARRY |-> ##3 instr_done && !carry_flag;
  endproperty
  a_clc: assert property (p_clc) else $error("bad clear carry");
  property p_sext;
    start && opcode == cbx_pkg::OP_SIGN_EXTEND |-> ##3 instr_done &&
      accumulator_word == {{8{$past(accumulator_word[7], 3)}}, $past(accumulator_word[7:0], 3)};
  endproperty
  a_sext: assert property (p_sext) else $error("bad sign extend");
  property p_near_push;
    start && opcode == cbx_pkg::OP_CALL_NEAR_REL |=> mem_req && mem_we &&
      mem_addr == stack_pointer - cbx_pkg::WORD_STEP && mem_wdata == $past(next_instr_addr);
  endproperty
  a_near_push: assert property (p_near_push) else $error("bad push");
  property p_near_cs;
    busy && opcode == cbx_pkg::OP_CALL_NEAR_REL |-> $stable(code_segment);
  endproperty
  a_near_cs: assert property (p_near_cs) else $error("cs moved");
  property p_rel_ip;
    instr_done && opcode == cbx_pkg::OP_CALL_NEAR_REL |-> instruction_pointer == next_instr_addr + imm_word0;
  endproperty
  a_rel_ip: assert property (p_rel_ip) else $error("bad rel ip");
  property p_reg_ip;
    instr_done && opcode == cbx_pkg::OP_GROUP_FF && modrm[5:3] == cbx_pkg::FF_REG_CALL_NEAR &&
      modrm[7:6] == cbx_pkg::MOD_REGISTER |-> instruction_pointer == operand_reg;
  endproperty
  a_reg_ip: assert property (p_reg_ip) else $error("bad reg ip");
  property p_far_imm;
    instr_done && opcode == cbx_pkg::OP_CALL_FAR_IMM |-> code_segment == imm_word1 &&
      instruction_pointer == imm_word0;
  endproperty
  a_far_imm: assert property (p_far_imm) else $error("bad far ptr");
endmodule

bind cbx_exec cbx_exec_sva u_cbx_exec_sva (.*);

// [dv/cbx_mem_model.sv]
`timescale 1ns/100ps
// ****
// Memory and stack
// ****
module cbx_mem_model (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        slow,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic            mem_ack,
  output logic     [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_cnt;
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst)
      wait_cnt <= 2'h0;
    else if (mem_req && !mem_ack)
    begin
      if (slow && wait_cnt != 2'h3)
        wait_cnt <= wait_cnt + 2'h1;
      else
      begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_we)
          mem[mem_addr[8:1]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[8:1]];
      end
    end
  end
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
// ****
// Bench
// ****
module tb;
  logic        clk, sys_rst, narrow_bus, instr_valid, operand_uses_stack, load_state, slow, trapped;
  logic [7:0]  opcode, modrm, trap_vector;
  logic [15:0] imm_word0, imm_word1, instr_addr, next_instr_addr, operand_reg, operand_addr, operand_disp;
  logic [15:0] code_segment_in, stack_pointer_in, accumulator_word_in, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] instruction_pointer, code_segment, stack_pointer, accumulator_word;
  logic        mem_req, mem_we, mem_ack, busy, instr_done, trap_req, carry_flag;
  int          n_errors, comparisons;

  cbx_exec u_cbx_exec (.*);
  cbx_mem_model u_mem (.*);

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic load(input logic [15:0] cs, input logic [15:0] sp, input logic [15:0] acc);
    @(posedge clk);
    code_segment_in <= cs;
    stack_pointer_in <= sp;
    accumulator_word_in <= acc;
    load_state <= 1'b1;
    @(posedge clk);
    load_state <= 1'b0;
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] md, input logic [15:0] i0, input logic [15:0] i1,
                     input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    opcode <= op;
    modrm <= md;
    imm_word0 <= i0;
    imm_word1 <= i1;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (instr_done !== 1'b1 && n < 300);
    trapped = trap_req;
    chk("done", 16'h0001, {15'h0, instr_done});
    if (exp != 16'h0)
      chk("cycles", exp, n[15:0]);
  endtask

  task automatic t_near_rel();
    load(16'h1234, 16'h0100, 16'h0000);
    @(posedge clk);
    next_instr_addr <= 16'h0203;
    run(cbx_pkg::OP_CALL_NEAR_REL, 8'h00, 16'hfff0, 16'h0, 16'd15);
    chk("ip", 16'h01f3, instruction_pointer);
    chk("cs", 16'h1234, code_segment);
    chk("sp", 16'h00fe, stack_pointer);
    chk("push", 16'h0203, u_mem.mem[8'h7f]);
    run(cbx_pkg::OP_NEAR_RETURN, 8'h00, 16'h0, 16'h0, 16'd16);
    chk("ret ip", 16'h0203, instruction_pointer);
    chk("ret sp", 16'h0100, stack_pointer);
    @(posedge clk);
    narrow_bus <= 1'b1;
    run(cbx_pkg::OP_CALL_NEAR_REL, 8'h00, 16'h0010, 16'h0, 16'd19);
    $display("near relative done");
  endtask

  task automatic t_near_ind();
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk);
      narrow_bus <= b[0];
      operand_reg <= 16'h4567;
      operand_addr <= 16'h0040;
      u_mem.mem[8'h20] = 16'h789a;
      run(cbx_pkg::OP_GROUP_FF, 8'hd0, 16'h0, 16'h0, b ? 16'd17 : 16'd13);
      chk("reg ip", 16'h4567, instruction_pointer);
      run(cbx_pkg::OP_GROUP_FF, 8'h16, 16'h0, 16'h0, b ? 16'd27 : 16'd19);
      chk("mem ip", 16'h789a, instruction_pointer);
    end
    $display("near indirect done");
  endtask

  task automatic t_far();
    for (int b = 0; b < 4; b++)
    begin
      @(posedge clk);
      narrow_bus <= b[0];
      operand_uses_stack <= b[1];
      operand_disp <= 16'h0004;
      next_instr_addr <= 16'h0300;
      u_mem.mem[8'h82] = 16'h5555;
      u_mem.mem[8'h83] = 16'h6666;
      load(16'h1234, 16'h0100, 16'h0000);
      if (b < 2)
      begin
        run(cbx_pkg::OP_CALL_FAR_IMM, 8'h00, 16'h1111, 16'h2222, b[0] ? 16'd31 : 16'd23);
        chk("far ip", 16'h1111, instruction_pointer);
        chk("far cs", 16'h2222, code_segment);
      end
      else
      begin
        run(cbx_pkg::OP_GROUP_FF, 8'h1e, 16'h0, 16'h0, b[0] ? 16'd54 : 16'd38);
        chk("far ip", 16'h5555, instruction_pointer);
        chk("far cs", 16'h6666, code_segment);
      end
      chk("far sp", 16'h00fc, stack_pointer);
      chk("push cs", 16'h1234, u_mem.mem[8'h7f]);
      chk("push ip", 16'h0300, u_mem.mem[8'h7e]);
    end
    @(posedge clk);
    operand_uses_stack <= 1'b0;
    $display("far calls done");
  endtask

  task automatic t_simple();
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk);
      narrow_bus <= b[0];
      load(16'h0000, 16'h0100, 16'h0080);
      run(cbx_pkg::OP_SIGN_EXTEND, 8'h00, 16'h0, 16'h0, 16'd2);
      chk("acc", 16'hff80, accumulator_word);
      load(16'h0000, 16'h0100, 16'h127f);
      run(cbx_pkg::OP_SIGN_EXTEND, 8'h00, 16'h0, 16'h0, 16'd2);
      chk("acc", 16'h007f, accumulator_word);
      run(cbx_pkg::OP_CLEAR_CARRY, 8'h00, 16'h0, 16'h0, 16'd2);
      chk("carry", 16'h0, {15'h0, carry_flag});
    end
    $display("extend and carry done");
  endtask

  task automatic t_bound();
    logic [15:0] idx [4] = '{16'hfffe, 16'h0010, 16'h0011, 16'hfffd};
    @(posedge clk);
    narrow_bus <= 1'b0;
    operand_addr <= 16'h0060;
    instr_addr <= 16'h0400;
    next_instr_addr <= 16'h0404;
    u_mem.mem[8'h30] = 16'hfffe;
    u_mem.mem[8'h31] = 16'h0010;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      operand_reg <= idx[i];
      slow <= (i == 3);
      run(cbx_pkg::OP_BOUND_CHECK, 8'h34, 16'h0, 16'h0, i < 3 ? 16'd33 : 16'd0);
      chk("trap", {15'h0, i > 1}, {15'h0, trapped});
      chk("bound ip", i > 1 ? 16'h0400 : 16'h0404, instruction_pointer);
    end
    $display("bounds done");
  endtask

  task automatic t_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    slow <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst ip", 16'h0, instruction_pointer);
    chk("rst sp", 16'h0, stack_pointer);
    chk("rst busy", 16'h0, {15'h0, busy});
    chk("rst vec", 16'h0, {8'h0, trap_vector});
    chk("rst req", 16'h0, {15'h0, mem_req});
    run(cbx_pkg::OP_CLEAR_CARRY, 8'h00, 16'h0, 16'h0, 16'd2);
    chk("rst next ip", 16'h0404, instruction_pointer);
    $display("reset done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    {narrow_bus, instr_valid, operand_uses_stack, load_state, slow, opcode, modrm} = '0;
    {imm_word0, imm_word1, instr_addr, next_instr_addr, operand_reg, operand_addr, operand_disp} = '0;
    {code_segment_in, stack_pointer_in, accumulator_word_in} = '0;
    n_errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_near_rel();
    t_near_ind();
    t_far();
    t_simple();
    t_bound();
    t_reset();
    end_of_test();
  end
endmodule
